// >>> bench/cbe_crc16_engine_props.sv
`timescale 1ns/1ps
module cbe_crc16_engine_props
  import cbe_pkg::*;
#(parameter int ADDR_W = 14, parameter int BLKCNT_W = 6) (
  input logic                sys_clk,
  input logic                rst_n,
  input logic                seedInit,
  input logic                seedOnes,
  input logic                busy,
  input logic                scanStart,
  input logic [BLKCNT_W-1:0] scanBlocks,
  input logic                flashRdEn,
  input logic [ADDR_W-1:0]   flashAddr,
  input logic                flashDataValid,
  input logic                scanDone,
  input logic [15:0]         checksum_unit
);
  // One clock domain, so one clocking and one reset for all
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  property p_seed; seedInit && !busy |=> checksum_unit == (seedOnes ? CBE_SEED_ONES : CBE_SEED_ZERO); endproperty
  a_seed: assert property (p_seed) else $error("seed not loaded");
  property p_rd; flashRdEn |=> !flashRdEn; endproperty
  a_rd: assert property (p_rd) else $error("read not a pulse");
  property p_addr; flashRdEn |=> $stable(flashAddr); endproperty
  a_addr: assert property (p_addr) else $error("address moved");
  property p_next; flashDataValid ##1 flashRdEn |-> flashAddr == $past(flashAddr) + 1'b1; endproperty
  a_next: assert property (p_next) else $error("address not next");
  property p_start; scanStart && !busy && scanBlocks != 0 |=> flashRdEn; endproperty
  a_start: assert property (p_start) else $error("scan not started");
  property p_zero; scanStart && !busy && scanBlocks == 0 |=> ##[0:1] scanDone; endproperty
  a_zero: assert property (p_zero) else $error("empty scan not done");
  property p_done; scanDone |=> !scanDone; endproperty
  a_done: assert property (p_done) else $error("done not a pulse");
  property p_chg; $changed(checksum_unit) |-> $past(busy) || $past(seedInit); endproperty
  a_chg: assert property (p_chg) else $error("sum changed unasked");
endmodule
bind cbe_crc16_engine cbe_crc16_engine_props #(.ADDR_W(ADDR_W), .BLKCNT_W(BLKCNT_W)) u_props (.*);

// >>> bench/cbe_crc16_engine_tb_top.sv
`timescale 1ns/1ps
module cbe_crc16_engine_tb_top import cbe_pkg::*;;
  logic sys_clk = 0, rst_n = 0, byteValid = 0, seedInit = 0, seedOnes = 0;
  logic bitReverse = 0, scanStart = 0, slow = 0, byteReady, flashRdEn, flashDataValid, busy, scanDone;
  logic [7:0] byteData = 8'h00, flashData;
  logic [13:0] scanBaseBlock = 14'h0000, flashAddr;
  logic [5:0] scanBlocks = 6'h00;
  logic [15:0] checksum_unit, expSum;
  int errors = 0, tests_run = 0, rdCount = 0;
  string digits = "123456789";
  cbe_crc16_engine i_dut (.*);
  cbe_flash_model u_flash (.*);
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (flashRdEn === 1'b1) rdCount++;
  // Reference fold, MSB first
  function automatic logic [15:0] fold(logic [15:0] c, logic [7:0] d);
    c ^= {d, 8'h00};
    for (int i = 0; i < 8; i++) c = c[15] ? (c << 1) ^ CBE_POLY : c << 1;
    return c;
  endfunction
  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(int n = 1);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask
  task automatic seed(logic ones);
    seedOnes = ones;
    seedInit = 1;
    tick();
    seedInit = 0;
    expSum = ones ? CBE_SEED_ONES : CBE_SEED_ZERO;
  endtask
  // Leaves byteValid up so bytes run back to back
  task automatic putByte(logic [7:0] d);
    logic [7:0] r;
    byteValid = 1;
    byteData = d;
    for (int i = 0; i < 30000 && byteReady !== 1'b1; i++) tick();
    tick();
    for (int i = 0; i < 8; i++) r[i] = d[7 - i];
    expSum = fold(expSum, bitReverse ? r : d);
  endtask
  task automatic settle(string what);
    for (int i = 0; i < 30000 && busy !== 1'b0; i++) tick();
    tick(2);
    chk(what, checksum_unit, expSum);
    $display("test %s done", what);
  endtask
  task automatic t_scan(logic [13:0] base, logic [5:0] n, logic s);
    logic [13:0] ad;
    slow = s;
    scanBaseBlock = base;
    scanBlocks = n;
    for (int a = 0; a < n * 256; a++) begin
      ad = (base << 8) + a;
      expSum = fold(expSum, ad[7:0] ^ ad[13:6]);
    end
    rdCount = 0;
    scanStart = 1;
    tick();
    scanStart = 0;
    if (n != 0) begin
      seedInit = 1; // Refused while scanning
      tick();
      seedInit = 0;
      for (int i = 0; i < 8; i++) putByte(8'(i));
      byteValid = 0;
      chk("full", 16'(byteReady), 16'h0000);
    end
    for (int i = 0; i < 30000 && scanDone !== 1'b1; i++) tick();
    chk("done", 16'(scanDone), 16'h0001);
    chk("reads", 16'(rdCount), 16'(n * 256));
    settle("scan");
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #1000000;
    errors++;
    print_verdict();
  end
  initial begin
    tick(6);
    rst_n = 1;
    chk("rst", checksum_unit, 16'h0000);
    seed(1);
    settle("ones");
    seed(0);
    settle("zeros");
    seed(1);
    foreach (digits[i]) putByte(digits[i]);
    byteValid = 0;
    settle("bytes");
    bitReverse = 1;
    putByte(8'h01);
    byteValid = 0;
    settle("rev");
    bitReverse = 0;
    t_scan(14'h0001, 6'h01, 0);
    t_scan(14'h003F, 6'h02, 1);
    t_scan(14'h0000, 6'h00, 0);
    print_verdict();
  end
endmodule

// >>> bench/cbe_flash_model.sv
`timescale 1ns/1ps
module cbe_flash_model #(parameter int AW = 14) (
  input  logic          sys_clk,
  input  logic          rst_n,
  input  logic          slow,
  input  logic          flashRdEn,
  input  logic [AW-1:0] flashAddr,
  output logic          flashDataValid,
  output logic [7:0]    flashData
);
  logic [1:0] waitReg;
  logic [7:0] byteReg;
  // Bus is not held outside the strobe, so stale data cannot pass
  assign flashData = flashDataValid ? byteReg : ~byteReg;
  // One read in flight; slow mode stalls, content hashes the address
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      waitReg <= 2'h0;
      byteReg <= 8'h00;
      flashDataValid <= 1'b0;
    end else begin
      flashDataValid <= waitReg == 2'h1;
      if (flashRdEn) waitReg <= slow ? 2'h3 : 2'h1;
      else if (waitReg != 2'h0) waitReg <= waitReg - 2'h1;
      if (flashRdEn) byteReg <= flashAddr[7:0] ^ flashAddr[AW-1:AW-8];
    end
  end
endmodule

// >>> design/cbe_crc16_engine.sv
`timescale 1ns/1ps
// Functional notes
// - CRC-16 with generator polynomial 0x1021
// - Fold each byte into 16-bit readable remainder
// - Seed remainder with zeros or ones selectably
// - Autonomous CRC over consecutive 256-byte flash blocks
module cbe_crc16_engine
  import cbe_pkg::*;
#(
  parameter int ADDR_W     = CBE_ADDR_W,
  parameter int BLKCNT_W   = CBE_BLKCNT_W,
  parameter int FIFO_DEPTH = CBE_FIFO_DEPTH
) (
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  input  wire logic                 byteValid,
  input  wire logic [7:0]           byteData,
  output logic                      byteReady,
  input  wire logic                 seedInit,
  input  wire logic                 seedOnes,
  input  wire logic                 bitReverse,
  input  wire logic                 scanStart,
  input  wire logic [ADDR_W-1:0]    scanBaseBlock,
  input  wire logic [BLKCNT_W-1:0]  scanBlocks,
  output logic                      flashRdEn,
  output logic [ADDR_W-1:0]         flashAddr,
  input  wire logic                 flashDataValid,
  input  wire logic [7:0]           flashData,
  output logic [15:0]               checksum_unit,
  output logic                      busy,
  output logic                      scanDone
);
  // Byte counter spans every byte of the largest scan request
  // Sized from the block count so a full request never wraps
  localparam int CNT_W = BLKCNT_W + CBE_BLOCK_LOG2;

  cbe_stream_if #(.W(CBE_BYTE_W)) inStream ();
  cbe_stream_if #(.W(CBE_BYTE_W)) outStream ();

  cbe_state_t         state_reg;
  cbe_state_t         state_next;
  logic [15:0]        crc_reg;
  logic [ADDR_W-1:0]  addr_reg;
  logic [CNT_W-1:0]   left_reg;
  logic               done_reg;
  logic               takeFifo;
  logic               takeFlash;
  logic [7:0]         foldByte;

  // One byte update, MSB first, eight unrolled shift steps
  // The loop unrolls into one XOR network, so a whole byte folds
  // in a single clock; the trade is a longer combinational path
  // in place of an eight-cycle serial shifter
  function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] din);
    logic [15:0] c;
    c = crc;
    for (int i = CBE_BYTE_W - 1; i >= 0; i--) begin
      if (c[15] ^ din[i]) begin
        c = {c[14:0], 1'b0} ^ CBE_POLY;
      end else begin
        c = {c[14:0], 1'b0};
      end
    end
    return c;
  endfunction

  // Optional byte-level bit reversal ahead of the fold
  // Pure rewiring; it costs no logic, only a mux on the byte path
  function automatic logic [7:0] rev_byte(input logic [7:0] b);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < CBE_BYTE_W; i++) begin
      r[i] = b[CBE_BYTE_W - 1 - i];
    end
    return r;
  endfunction

  // Processor bytes queue in the FIFO; full FIFO back-pressures the writer
  // The writer must hold its byte while byteReady is low;
  // a byte dropped here would silently corrupt the checksum
  assign inStream.valid = byteValid;
  assign inStream.data  = byteData;
  assign byteReady      = inStream.ready;

  cbe_fifo #(
    .W     (CBE_BYTE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .inPort  (inStream),
    .outPort (outStream)
  );

  // FIFO drains only while idle and not seeding, so a scan stalls the writer
  // Holding queued bytes back keeps flash and processor bytes from
  // interleaving; they fold after the scan in the order written
  // Seeding also holds the drain so a seed never lands mid-byte
  assign outStream.ready = (state_reg == CBE_IDLE) && !seedInit && !scanStart;
  assign takeFifo        = outStream.valid && outStream.ready;
  assign takeFlash       = (state_reg == CBE_FLASH_WAIT) && flashDataValid;

  // Byte source select and optional reversal
  // Flash bytes take priority; the FIFO is never drained while
  // a scan is active, so both sources cannot fold in one cycle
  always_comb begin
    foldByte = takeFlash ? flashData : outStream.data;
    if (bitReverse) begin
      foldByte = rev_byte(foldByte);
    end
  end

  // Running remainder: seeding while idle wins over any byte in the same cycle
  // A seed request during a scan is ignored, so the scan result
  // cannot be cut short by a late reseed from software
  // Reset leaves the all-zeros seed in place
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      crc_reg <= CBE_SEED_ZERO;
    end else if (seedInit && (state_reg == CBE_IDLE)) begin
      crc_reg <= seedOnes ? CBE_SEED_ONES : CBE_SEED_ZERO;
    end else if (takeFifo || takeFlash) begin
      crc_reg <= crc_byte(crc_reg, foldByte);
    end
  end

  // Scan sequencer next state
  // Only one flash read is outstanding at a time; the next request
  // is raised the cycle after data returns, which suits any latency
  // at the price of one idle cycle per byte
  // An empty request never leaves idle; it only pulses scanDone
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      CBE_IDLE: begin
        if (scanStart && (scanBlocks != '0)) begin
          state_next = CBE_FLASH_REQ;
        end
      end
      CBE_FLASH_REQ: begin
        state_next = CBE_FLASH_WAIT;
      end
      CBE_FLASH_WAIT: begin
        if (flashDataValid) begin
          state_next = (left_reg == CNT_W'(1)) ? CBE_IDLE : CBE_FLASH_REQ;
        end
      end
      default: begin
        state_next = CBE_IDLE;
      end
    endcase
  end

  // State register
  // Reset returns the sequencer to idle, abandoning any scan
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= CBE_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Address and byte count; a scan always starts on a block boundary
  // The address wraps at the top of the flash space; a request that
  // runs past the end continues from address zero
  // The count holds whole blocks times the block size
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_reg <= '0;
      left_reg <= '0;
    end else if ((state_reg == CBE_IDLE) && scanStart) begin
      addr_reg <= ADDR_W'(scanBaseBlock << CBE_BLOCK_LOG2);
      left_reg <= {scanBlocks, CBE_BLOCK_LOG2'(0)};
    end else if (takeFlash) begin
      addr_reg <= addr_reg + 1'b1;
      left_reg <= left_reg - 1'b1;
    end
  end

  // Completion pulse, also given for an empty scan request
  // Registered so the pulse lines up with the final checksum value
  // Software polling busy sees it fall in the same cycle only when no bytes are queued in the FIFO
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= (takeFlash && (left_reg == CNT_W'(1)))
                  || ((state_reg == CBE_IDLE) && scanStart && (scanBlocks == '0));
    end
  end

  // Outputs: read strobe from state, data outputs from registers
  // busy stays high while queued bytes remain unfolded
  // so software knows the checksum is not yet final
  assign flashRdEn     = (state_reg == CBE_FLASH_REQ);
  assign flashAddr     = addr_reg;
  assign checksum_unit = crc_reg;
  assign scanDone      = done_reg;
  assign busy          = (state_reg != CBE_IDLE) || outStream.valid; // Queued bytes still pending
endmodule

// >>> design/cbe_fifo.sv
`timescale 1ns/1ps
module cbe_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  cbe_stream_if.snk inPort,
  cbe_stream_if.src outPort
);
  localparam int PW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [PW:0]   wrPtr_reg;
  logic [PW:0]   rdPtr_reg;
  logic          full;
  logic          empty;
  logic          push;
  logic          pop;

  // Extra pointer bit tells full from empty when the indices match
  assign empty         = (wrPtr_reg == rdPtr_reg);
  assign full          = (wrPtr_reg[PW] != rdPtr_reg[PW]) && (wrPtr_reg[PW-1:0] == rdPtr_reg[PW-1:0]);
  assign inPort.ready  = !full;
  assign outPort.valid = !empty;
  assign outPort.data  = mem[rdPtr_reg[PW-1:0]];
  assign push          = inPort.valid && !full;
  assign pop           = !empty && outPort.ready;

  // Storage has no reset; only pointers carry state
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wrPtr_reg[PW-1:0]] <= inPort.data;
    end
  end

  // Pointer update
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
    end else begin
      if (push) begin
        wrPtr_reg <= wrPtr_reg + 1'b1;
      end
      if (pop) begin
        rdPtr_reg <= rdPtr_reg + 1'b1;
      end
    end
  end
endmodule

// >>> design/cbe_pkg.sv
package cbe_pkg;
  localparam int          CBE_CRC_W      = 16;
  localparam int          CBE_BYTE_W     = 8;
  localparam logic [15:0] CBE_POLY       = 16'h1021;
  localparam logic [15:0] CBE_SEED_ZERO  = 16'h0000;
  localparam logic [15:0] CBE_SEED_ONES  = 16'hFFFF;
  localparam int          CBE_BLOCK_LOG2 = 8;
  localparam int          CBE_FIFO_DEPTH = 8;
  localparam int          CBE_ADDR_W     = 14;
  localparam int          CBE_BLKCNT_W   = 6;

  typedef enum logic [1:0] {
    CBE_IDLE,
    CBE_FLASH_REQ,
    CBE_FLASH_WAIT
  } cbe_state_t;
endpackage

// >>> design/cbe_stream_if.sv
`timescale 1ns/1ps
interface cbe_stream_if #(
  parameter int W = 8
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
